// [hw/touch_pkg.sv]
// constants, register map and types for the touch post-processing engine
// assumes one sensing cycle result presented per cycle_valid pulse
package touch_pkg;

  // ****************************************************************
  // bus and register map (word offsets)
  // ****************************************************************
  localparam int          DW          = 16;
  localparam int          AW          = 5;
  localparam logic [4:0]  REG_CTRL    = 5'h00;
  localparam logic [4:0]  REG_RES_X   = 5'h01;
  localparam logic [4:0]  REG_RES_Y   = 5'h02;
  localparam logic [4:0]  REG_LINES   = 5'h03;
  localparam logic [4:0]  REG_PALM    = 5'h04;
  localparam logic [4:0]  REG_STILL   = 5'h05;
  localparam logic [4:0]  REG_IDLE_MS = 5'h06;
  localparam logic [4:0]  REG_SPLIT   = 5'h07;
  localparam logic [4:0]  REG_BETA    = 5'h08;
  localparam logic [4:0]  REG_SPEED   = 5'h09;
  localparam logic [4:0]  REG_GEST_EN = 5'h0a;
  localparam logic [4:0]  REG_TAP_MS  = 5'h0b;
  localparam logic [4:0]  REG_HOLD_MS = 5'h0c;
  localparam logic [4:0]  REG_TAP_DST = 5'h0d;
  localparam logic [4:0]  REG_SW_IDST = 5'h0e;
  localparam logic [4:0]  REG_SW_IMS  = 5'h0f;
  localparam logic [4:0]  REG_SW_CDST = 5'h10;
  localparam logic [4:0]  REG_SW_CMS  = 5'h11;
  localparam logic [4:0]  REG_SW_ANG  = 5'h12;
  localparam int          NUM_CFG     = 19;
  localparam logic [4:0]  REG_STATUS  = 5'h13;
  localparam logic [4:0]  REG_ABS_X   = 5'h14;
  localparam logic [4:0]  REG_ABS_Y   = 5'h15;
  localparam logic [4:0]  REG_REL_X   = 5'h16;
  localparam logic [4:0]  REG_REL_Y   = 5'h17;
  localparam logic [4:0]  REG_FINGERS = 5'h18;

  localparam logic [15:0] CFG_RESET [NUM_CFG] = '{
    16'h0030, 16'h0300, 16'h0200, 16'h0a0f, 16'h0a10, 16'h0010,
    16'h03e8, 16'h0001, 16'h80ff, 16'h4008, 16'h0000, 16'h00c8,
    16'h012c, 16'h0032, 16'h0096, 16'h012c, 16'h00c8, 16'h00c8,
    16'h0017};

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int CTRL_PALM_EN   = 0;
  localparam int CTRL_FLIP_X    = 1;
  localparam int CTRL_FLIP_Y    = 2;
  localparam int CTRL_EXCHANGE  = 3;
  localparam int CTRL_MAV_EN    = 4;
  localparam int CTRL_IIR_EN    = 5;
  localparam int CTRL_STATIC    = 6;
  localparam int GE_TAP         = 0;
  localparam int GE_HOLD        = 1;
  localparam int GE_SWIPE_BASE  = 2;
  localparam int ST_PALM        = 0;
  localparam int ST_MOTION      = 1;
  localparam int ST_IDLE_TOUCH  = 2;
  localparam int ST_TAP         = 3;
  localparam int ST_HOLD        = 4;
  localparam int ST_SWIPE_BASE  = 5;

  // ****************************************************************
  // arithmetic constants
  // ****************************************************************
  localparam int          SUB_SHIFT    = 8;
  localparam logic [8:0]  BETA_FULL    = 9'h100;
  localparam int          ANGLE_SHIFT  = 6;
  localparam logic [15:0] PALM_STEP_MS = 16'h0020;
  localparam logic [15:0] SAT16        = 16'hffff;

  typedef enum logic [1:0] {
    gs_idle  = 2'b00,
    gs_track = 2'b01,
    gs_hold  = 2'b10,
    gs_void  = 2'b11
  } gest_state_t;

endpackage : touch_pkg

// [hw/touch_xy_postprocess_gesture_engine.sv]
// touch position post-processing and one-finger gesture engine
// assumes sensing logic presents one result per cycle_valid pulse
//
// Overview of operation
// - scale 256-substep positions to output resolution
// - oversized contact sets flag, suppresses XY
// - large contact latched timeout times 32 ms
// - still touch within threshold enters idle-touch
// - movement beyond threshold sets motion flag
// - split factor zero merges adjacent touches
// - default axis order, flips, axis exchange
// - averaging filter first, recursive filter second
// - average of current and previous raw point
// - damping is coefficient over 256, variant select
// - dynamic variant eases filtering with speed
// - static variant uses fixed coefficient
// - per-gesture enable bits for one-finger gestures
// - gestures from origin, extra touches invalidate
// - tap: quick release within tap distance
// - tap flagged release cycle, relative zero
// - tap location in finger one, count zero
// - hold after tap plus hold time, then relative
// - swipe sign by direction, axis by parallelism
// - swipe needs distance, time and angle limit
// - swipe flag one cycle, distance in relative
// - consecutive swipes restart, direction locked
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps

module touch_xy_postprocess_gesture_engine
  import touch_pkg::*;
(
  // clock and reset
  input  wire logic               clock,
  input  wire logic               rst,
  // register port
  input  wire logic [AW-1:0]      addr,
  input  wire logic [DW-1:0]      wr_data,
  input  wire logic               wr_stb,
  input  wire logic               rd_stb,
  output logic      [DW-1:0]      rd_data,
  // sensing cycle result
  input  wire logic               cycle_valid,
  input  wire logic [15:0]        raw_col_pos,
  input  wire logic [15:0]        raw_row_pos,
  input  wire logic [2:0]         merged_count,
  input  wire logic [2:0]         split_count,
  input  wire logic [7:0]         finger_area,
  input  wire logic [15:0]        cycle_ms,
  // report outputs
  output logic      [15:0]        abs_x,
  output logic      [15:0]        abs_y,
  output logic      [15:0]        rel_x,
  output logic      [15:0]        rel_y,
  output logic      [2:0]         fingers_out,
  output logic                    palm_flag,
  output logic                    motion_flag,
  output logic                    idle_touch,
  output logic                    tap_flag,
  output logic                    hold_flag,
  output logic      [3:0]         swipe_flags
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [15:0] sat_add(input logic [15:0] a,
                                          input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[16] ? SAT16 : s[15:0];
  endfunction : sat_add

  function automatic logic signed [16:0] sdiff(input logic [15:0] a,
                                               input logic [15:0] b);
    return $signed({1'b0, a}) - $signed({1'b0, b});
  endfunction : sdiff

  function automatic logic [15:0] adiff(input logic [15:0] a,
                                        input logic [15:0] b);
    return (a > b) ? a - b : b - a;
  endfunction : adiff

  function automatic logic [15:0] scale_pos(input logic [15:0] raw,
                                            input logic [15:0] res,
                                            input logic [4:0]  lines);
    logic [15:0] span;
    logic [31:0] q;
    span = {3'h0, lines - 5'h01, 8'h00};
    q    = 32'h0;
    if (lines > 5'h01) begin
      q = ({16'h0, raw} * {16'h0, res}) / {16'h0, span};
    end
    return (q > {16'h0, res}) ? res : q[15:0];
  endfunction : scale_pos

  function automatic logic [15:0] iir_step(input logic [15:0] prev,
                                           input logic [15:0] in,
                                           input logic [8:0]  beta);
    logic signed [26:0] prod;
    logic signed [26:0] sum;
    prod = 27'(sdiff(in, prev)) * $signed({18'h0, beta});
    sum  = $signed({11'h0, prev}) + (prod >>> SUB_SHIFT);
    return sum[15:0];
  endfunction : iir_step

  // ****************************************************************
  // configuration registers and read port
  // ****************************************************************
  logic [15:0]  cfg_ff [NUM_CFG];
  logic [15:0]  status_word;

  always_ff @(posedge clock) begin
    for (int i = 0; i < NUM_CFG; i++) begin
      if (rst) begin
        cfg_ff[i] <= CFG_RESET[i];
      end else if (wr_stb && addr == AW'(i)) begin
        cfg_ff[i] <= wr_data;
      end
    end
  end

  logic [15:0] ctrl;
  logic [7:0]  gest_one_en;
  assign ctrl        = cfg_ff[REG_CTRL];
  assign gest_one_en = cfg_ff[REG_GEST_EN][7:0];

  always_ff @(posedge clock) begin
    if (rst) begin
      rd_data <= 16'h0000;
    end else if (rd_stb) begin
      unique case (addr)
        REG_STATUS:  rd_data <= status_word;
        REG_ABS_X:   rd_data <= abs_x;
        REG_ABS_Y:   rd_data <= abs_y;
        REG_REL_X:   rd_data <= rel_x;
        REG_REL_Y:   rd_data <= rel_y;
        REG_FINGERS: rd_data <= {13'h0, fingers_out};
        default: begin
          rd_data <= (addr < AW'(NUM_CFG)) ? cfg_ff[addr] : 16'h0000;
        end
      endcase
    end else begin
      rd_data <= 16'h0000;
    end
  end

  assign status_word = {7'h0, swipe_flags, hold_flag, tap_flag,
                        idle_touch, motion_flag, palm_flag};

  // ****************************************************************
  // orientation and scaling
  // ****************************************************************
  logic [15:0] ori_x_raw, ori_y_raw, scl_x, scl_y, pos_x, pos_y;
  logic [4:0]  lines_x, lines_y;

  always_comb begin
    // exchange lets x follow the row lines
    ori_x_raw = ctrl[CTRL_EXCHANGE] ? raw_row_pos : raw_col_pos;
    ori_y_raw = ctrl[CTRL_EXCHANGE] ? raw_col_pos : raw_row_pos;
    lines_x   = ctrl[CTRL_EXCHANGE] ? cfg_ff[REG_LINES][12:8]
                                    : cfg_ff[REG_LINES][4:0];
    lines_y   = ctrl[CTRL_EXCHANGE] ? cfg_ff[REG_LINES][4:0]
                                    : cfg_ff[REG_LINES][12:8];
    scl_x = scale_pos(ori_x_raw, cfg_ff[REG_RES_X], lines_x);
    scl_y = scale_pos(ori_y_raw, cfg_ff[REG_RES_Y], lines_y);
    pos_x = ctrl[CTRL_FLIP_X] ? cfg_ff[REG_RES_X] - scl_x : scl_x;
    pos_y = ctrl[CTRL_FLIP_Y] ? cfg_ff[REG_RES_Y] - scl_y : scl_y;
  end

  // ****************************************************************
  // palm rejection and finger count
  // ****************************************************************
  logic [15:0] palm_ms_ff;
  logic [2:0]  count_eff;
  logic        big_contact, palm_active, touch, single;

  always_comb begin
    count_eff   = (cfg_ff[REG_SPLIT][7:0] == 8'h00) ? merged_count
                                                    : split_count;
    big_contact = ctrl[CTRL_PALM_EN] && count_eff != 3'h0 &&
                  finger_area > cfg_ff[REG_PALM][7:0];
    palm_active = big_contact || palm_ms_ff != 16'h0000;
    touch       = count_eff != 3'h0 && !palm_active;
    single      = touch && count_eff == 3'h1;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      palm_ms_ff <= 16'h0000;
    end else if (cycle_valid) begin
      if (big_contact) begin
        palm_ms_ff <= PALM_STEP_MS * {8'h0, cfg_ff[REG_PALM][15:8]};
      end else begin
        palm_ms_ff <= (palm_ms_ff > cycle_ms) ? palm_ms_ff - cycle_ms
                                              : 16'h0000;
      end
    end
  end

  // ****************************************************************
  // averaging then recursive smoothing
  // ****************************************************************
  logic [15:0] prev_x_ff, prev_y_ff, filt_x_ff, filt_y_ff;
  logic        had_touch_ff;
  logic [15:0] avg_x, avg_y, sm_x, sm_y, speed;
  logic [8:0]  beta, bottom;
  logic [7:0]  lo_spd, hi_spd;
  logic [17:0] ramp;

  always_comb begin
    avg_x = pos_x;
    avg_y = pos_y;
    if (ctrl[CTRL_MAV_EN] && had_touch_ff) begin
      avg_x = 16'(({1'b0, pos_x} + {1'b0, prev_x_ff}) >> 1);
      avg_y = 16'(({1'b0, pos_y} + {1'b0, prev_y_ff}) >> 1);
    end
    speed  = adiff(avg_x, filt_x_ff);
    if (adiff(avg_y, filt_y_ff) > speed) begin
      speed = adiff(avg_y, filt_y_ff);
    end
    bottom = {1'b0, cfg_ff[REG_BETA][7:0]};
    lo_spd = cfg_ff[REG_SPEED][7:0];
    hi_spd = cfg_ff[REG_SPEED][15:8];
    ramp   = 18'h0;
    if (ctrl[CTRL_STATIC]) begin
      beta = {1'b0, cfg_ff[REG_BETA][15:8]};
    end else if (speed <= {8'h0, lo_spd}) begin
      beta = bottom;
    end else if (speed >= {8'h0, hi_spd}) begin
      beta = BETA_FULL;
    end else begin
      ramp = ({2'h0, speed - {8'h0, lo_spd}} * {9'h0, BETA_FULL - bottom})
             / {10'h0, hi_spd - lo_spd};
      beta = bottom + ramp[8:0];
    end
    sm_x = avg_x;
    sm_y = avg_y;
    // filters run in fixed order: average feeds the recursion
    if (ctrl[CTRL_IIR_EN] && had_touch_ff) begin
      sm_x = iir_step(filt_x_ff, avg_x, beta);
      sm_y = iir_step(filt_y_ff, avg_y, beta);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      prev_x_ff    <= 16'h0000;
      prev_y_ff    <= 16'h0000;
      filt_x_ff    <= 16'h0000;
      filt_y_ff    <= 16'h0000;
      had_touch_ff <= 1'b0;
    end else if (cycle_valid) begin
      prev_x_ff    <= pos_x;
      prev_y_ff    <= pos_y;
      filt_x_ff    <= sm_x;
      filt_y_ff    <= sm_y;
      had_touch_ff <= touch;
    end
  end

  // ****************************************************************
  // stationary touch and motion
  // ****************************************************************
  logic [15:0] anc_x_ff, anc_y_ff, still_ms_ff;
  logic        moved;

  assign moved = touch && had_touch_ff &&
                 (adiff(sm_x, anc_x_ff) > cfg_ff[REG_STILL] ||
                  adiff(sm_y, anc_y_ff) > cfg_ff[REG_STILL]);

  always_ff @(posedge clock) begin
    if (rst) begin
      anc_x_ff    <= 16'h0000;
      anc_y_ff    <= 16'h0000;
      still_ms_ff <= 16'h0000;
      motion_flag <= 1'b0;
      idle_touch  <= 1'b0;
    end else if (cycle_valid) begin
      motion_flag <= moved;
      if (!touch || !had_touch_ff || moved) begin
        anc_x_ff    <= sm_x;
        anc_y_ff    <= sm_y;
        still_ms_ff <= 16'h0000;
        idle_touch  <= 1'b0;
      end else begin
        still_ms_ff <= sat_add(still_ms_ff, cycle_ms);
        idle_touch  <= sat_add(still_ms_ff, cycle_ms) >=
                       cfg_ff[REG_IDLE_MS];
      end
    end
  end

  // ****************************************************************
  // one-finger gestures
  // ****************************************************************
  gest_state_t     state_ff;
  logic [15:0]     org_x_ff, org_y_ff, g_ms_ff, sw_x_ff, sw_y_ff, s_ms_ff;
  logic            dev_ff, lock_ff;
  logic [1:0]      lock_dir_ff;
  logic [15:0]     g_ms_nxt, s_ms_nxt, sw_dst, sw_time, adx, ady;
  logic [23:0]     lim_x, lim_y;
  logic            dev_nxt, hit_x, hit_y, swipe_hit, tap_ok, hold_ok;
  logic [1:0]      dir;

  always_comb begin
    g_ms_nxt = sat_add(g_ms_ff, cycle_ms);
    s_ms_nxt = sat_add(s_ms_ff, cycle_ms);
    dev_nxt  = dev_ff || adiff(sm_x, org_x_ff) > cfg_ff[REG_TAP_DST] ||
               adiff(sm_y, org_y_ff) > cfg_ff[REG_TAP_DST];
    tap_ok   = gest_one_en[GE_TAP] && !dev_ff &&
               g_ms_ff < cfg_ff[REG_TAP_MS];
    hold_ok  = gest_one_en[GE_HOLD] && !dev_nxt &&
               {1'b0, g_ms_nxt} > {1'b0, cfg_ff[REG_TAP_MS]} +
                                  {1'b0, cfg_ff[REG_HOLD_MS]};
    sw_dst   = lock_ff ? cfg_ff[REG_SW_CDST] : cfg_ff[REG_SW_IDST];
    sw_time  = lock_ff ? cfg_ff[REG_SW_CMS]  : cfg_ff[REG_SW_IMS];
    adx      = adiff(sm_x, sw_x_ff);
    ady      = adiff(sm_y, sw_y_ff);
    lim_x    = {8'h0, adx} * {8'h0, cfg_ff[REG_SW_ANG]};
    lim_y    = {8'h0, ady} * {8'h0, cfg_ff[REG_SW_ANG]};
    hit_x    = adx > sw_dst && s_ms_nxt <= sw_time &&
               ({8'h0, ady} << ANGLE_SHIFT) <= lim_x;
    hit_y    = ady > sw_dst && s_ms_nxt <= sw_time &&
               ({8'h0, adx} << ANGLE_SHIFT) <= lim_y;
    // bit 1 of dir picks the y axis, bit 0 the positive sense
    if (lock_ff) begin
      dir   = lock_dir_ff;
      hit_x = hit_x && !lock_dir_ff[1];
      hit_y = hit_y && lock_dir_ff[1];
    end else if (hit_x) begin
      dir = {1'b0, sm_x > sw_x_ff};
    end else begin
      dir = {1'b1, sm_y > sw_y_ff};
    end
    swipe_hit = (hit_x || hit_y) &&
                (dir[0] == (hit_x ? sm_x > sw_x_ff : sm_y > sw_y_ff)) &&
                gest_one_en[GE_SWIPE_BASE + 32'(dir)];
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_ff    <= gs_idle;
      org_x_ff    <= 16'h0000;
      org_y_ff    <= 16'h0000;
      g_ms_ff     <= 16'h0000;
      s_ms_ff     <= 16'h0000;
      sw_x_ff     <= 16'h0000;
      sw_y_ff     <= 16'h0000;
      dev_ff      <= 1'b0;
      lock_ff     <= 1'b0;
      lock_dir_ff <= 2'b00;
      tap_flag    <= 1'b0;
      hold_flag   <= 1'b0;
      swipe_flags <= 4'h0;
    end else if (cycle_valid) begin
      tap_flag    <= 1'b0;
      swipe_flags <= 4'h0;
      unique case (state_ff)
        gs_idle: begin
          if (single) begin
            state_ff <= gs_track;
            org_x_ff <= sm_x;
            org_y_ff <= sm_y;
            sw_x_ff  <= sm_x;
            sw_y_ff  <= sm_y;
            g_ms_ff  <= 16'h0000;
            s_ms_ff  <= 16'h0000;
            dev_ff   <= 1'b0;
            lock_ff  <= 1'b0;
          end else if (count_eff != 3'h0) begin
            state_ff <= gs_void;
          end
        end
        gs_track: begin
          if (count_eff == 3'h0 && !palm_active) begin
            tap_flag <= tap_ok;
            state_ff <= gs_idle;
          end else if (!single) begin
            state_ff <= gs_void;
          end else if (hold_ok) begin
            hold_flag <= 1'b1;
            state_ff  <= gs_hold;
          end else begin
            g_ms_ff <= g_ms_nxt;
            dev_ff  <= dev_nxt;
            s_ms_ff <= s_ms_nxt;
            if (swipe_hit) begin
              swipe_flags[dir] <= 1'b1;
              sw_x_ff     <= sm_x;
              sw_y_ff     <= sm_y;
              s_ms_ff     <= 16'h0000;
              lock_ff     <= 1'b1;
              lock_dir_ff <= dir;
            end
          end
        end
        gs_hold: begin
          if (!single) begin
            hold_flag <= 1'b0;
            state_ff  <= (count_eff == 3'h0) ? gs_idle : gs_void;
          end
        end
        gs_void: begin
          if (count_eff == 3'h0) begin
            state_ff <= gs_idle;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // reported coordinates
  // ****************************************************************
  logic quiet_rel;
  // within tap bounds with hold enabled, motion is held back
  assign quiet_rel = state_ff == gs_track && gest_one_en[GE_HOLD] &&
                     !dev_nxt;

  always_ff @(posedge clock) begin
    if (rst) begin
      abs_x       <= 16'h0000;
      abs_y       <= 16'h0000;
      rel_x       <= 16'h0000;
      rel_y       <= 16'h0000;
      fingers_out <= 3'h0;
      palm_flag   <= 1'b0;
    end else if (cycle_valid) begin
      palm_flag   <= palm_active;
      fingers_out <= touch ? count_eff : 3'h0;
      rel_x       <= 16'h0000;
      rel_y       <= 16'h0000;
      if (touch) begin
        abs_x <= sm_x;
        abs_y <= sm_y;
        if (single && had_touch_ff && !quiet_rel) begin
          rel_x <= 16'(sdiff(sm_x, filt_x_ff));
          rel_y <= 16'(sdiff(sm_y, filt_y_ff));
        end
      end else if (!(state_ff == gs_track && tap_ok && !palm_active)) begin
        abs_x <= 16'h0000;
        abs_y <= 16'h0000;
      end
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_release_cycle;
    cycle_valid && state_ff == gs_track && count_eff == 3'h0;
  endsequence

  a_tap_one_cycle: assert property (
    tap_flag && cycle_valid |=> !tap_flag)
    else $error("tap flag held past next cycle");
  a_tap_location: assert property (
    tap_flag |-> fingers_out == 3'h0 && rel_x == 16'h0 && rel_y == 16'h0)
    else $error("tap report shows active finger or motion");
  a_tap_cause: assert property (
    $rose(tap_flag) |-> $past(state_ff == gs_track && tap_ok))
    else $error("tap without valid release");
  a_tap_release: assert property (
    s_release_cycle ##0 (tap_ok && !palm_active) |=> tap_flag)
    else $error("valid tap not flagged");
  a_swipe_one_cycle: assert property (
    swipe_flags != 4'h0 && cycle_valid |=> swipe_flags == 4'h0)
    else $error("swipe flag longer than a cycle");
  a_swipe_enabled: assert property (
    $rose(swipe_flags[0]) |-> $past(gest_one_en[GE_SWIPE_BASE]))
    else $error("disabled swipe reported");
  a_palm_suppress: assert property (
    palm_flag |-> fingers_out == 3'h0 && abs_x == 16'h0)
    else $error("xy shown during large contact");
  a_hold_drop: assert property (
    hold_flag && cycle_valid && !single |=> !hold_flag)
    else $error("hold not cleared on release");
  a_motion_stable: assert property (
    !$past(cycle_valid) |-> $stable(motion_flag))
    else $error("motion flag changed outside a cycle");
  a_rd_ctrl: assert property (
    rd_stb && addr == REG_CTRL |=> rd_data == $past(ctrl))
    else $error("control readback wrong");

endmodule : touch_xy_postprocess_gesture_engine

// [testbench/touch_source.sv]
// sensing-cycle source standing in for the channel sensing front end
// assumes the bench raises go for exactly one clock per sensing cycle
`timescale 1ns/1ps

module touch_source #(
  parameter logic [15:0] CYCLE_LEN = 16'h0064
) (
  // clock
  input  wire logic        clock,
  // bench request
  input  wire logic        go,
  input  wire logic [15:0] col,
  input  wire logic [15:0] row,
  input  wire logic [2:0]  cnt,
  input  wire logic [7:0]  area,
  // sensing cycle result
  output logic             cycle_valid,
  output logic      [15:0] raw_col_pos,
  output logic      [15:0] raw_row_pos,
  output logic      [2:0]  merged_count,
  output logic      [2:0]  split_count,
  output logic      [7:0]  finger_area,
  output logic      [15:0] cycle_ms
);
  // one pulse per request, results held until the next request
  always_ff @(posedge clock) begin
    cycle_valid <= go;
    if (go) begin
      raw_col_pos  <= col;
      raw_row_pos  <= row;
      merged_count <= cnt;
      split_count  <= cnt;
      finger_area  <= area;
      cycle_ms     <= CYCLE_LEN;
    end
  end
endmodule : touch_source

// [testbench/testbench.sv]
// self-checking bench for the touch post-processing engine
// assumes 10 MHz clock, sensing cycles 100 ms long each
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end

module testbench;
  import touch_pkg::*;
  logic        clock = 0, rst = 1, wr_stb = 0, rd_stb = 0, go = 0;
  logic [4:0]  addr = '0;
  logic [15:0] wr_data = '0, col = '0, row = '0, q;
  logic [2:0]  cnt = '0, mc, sc, fingers_out;
  logic [7:0]  area = '0, fa;
  logic [15:0] rd_data, rc, rr, ms, abs_x, abs_y, rel_x, rel_y;
  logic        cv, palm_flag, motion_flag, idle_touch, tap_flag, hold_flag;
  logic [3:0]  swipe_flags;
  int          fails = 0, num_checks = 0, cyc = 0;

  always #50 clock = ~clock;

  touch_source src_u (.clock(clock), .go(go), .col(col), .row(row),
    .cnt(cnt), .area(area), .cycle_valid(cv), .raw_col_pos(rc),
    .raw_row_pos(rr), .merged_count(mc), .split_count(sc),
    .finger_area(fa), .cycle_ms(ms));

  touch_xy_postprocess_gesture_engine dut_u (.clock(clock), .rst(rst),
    .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rd_data(rd_data), .cycle_valid(cv), .raw_col_pos(rc),
    .raw_row_pos(rr), .merged_count(mc), .split_count(sc),
    .finger_area(fa), .cycle_ms(ms), .abs_x(abs_x), .abs_y(abs_y),
    .rel_x(rel_x), .rel_y(rel_y), .fingers_out(fingers_out),
    .palm_flag(palm_flag), .motion_flag(motion_flag),
    .idle_touch(idle_touch), .tap_flag(tap_flag), .hold_flag(hold_flag),
    .swipe_flags(swipe_flags));

  task results;
    if (fails == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results

  task wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clock) begin addr <= a; wr_data <= d; wr_stb <= 1'b1; end
    @(posedge clock) wr_stb <= 1'b0;
  endtask : wr

  task rd(input logic [4:0] a);
    @(posedge clock) begin addr <= a; rd_stb <= 1'b1; end
    @(posedge clock) rd_stb <= 1'b0;
    #1 q = rd_data;
  endtask : rd

  // one sensing cycle; outputs are settled when this returns
  task snd(input logic [15:0] c, r, input logic [2:0] n, input logic [7:0] s);
    @(posedge clock) begin col <= c; row <= r; cnt <= n; area <= s;
      go <= 1'b1; end
    @(posedge clock) go <= 1'b0;
    @(posedge clock) #1;
  endtask : snd

  task t_regs;
    rd(REG_CTRL); `CHK(q, 16'h0030)
    rd(REG_GEST_EN); `CHK(q, 16'h0000)
    wr(REG_STATUS, 16'hffff); rd(REG_STATUS); `CHK(q, 16'h0000)
    rd(5'h1f); `CHK(q, 16'h0000)
  endtask : t_regs

  task t_tap;
    wr(REG_CTRL, 16'h0000); wr(REG_GEST_EN, 16'h0001);
    snd(16'h0700, 16'h0480, 3'h1, 8'h01); `CHK(fingers_out, 3'h1)
    snd(16'h0000, 16'h0000, 3'h0, 8'h00); `CHK(tap_flag, 1'b1)
    `CHK(abs_x, 16'h0180)
    `CHK(abs_y, 16'h0100)
    `CHK(fingers_out, 3'h0)
    `CHK(rel_x, 16'h0000)
    snd(16'h0000, 16'h0000, 3'h0, 8'h00); `CHK(tap_flag, 1'b0)
  endtask : t_tap

  task t_flip;
    wr(REG_CTRL, 16'h0002);
    snd(16'h0e00, 16'h0480, 3'h1, 8'h01); `CHK(abs_x, 16'h0000)
    `CHK(abs_y, 16'h0100)
    snd(16'h0000, 16'h0480, 3'h1, 8'h01); `CHK(abs_x, 16'h0300)
    `CHK(motion_flag, 1'b1)
    snd(16'h0000, 16'h0000, 3'h0, 8'h00); `CHK(tap_flag, 1'b0)
  endtask : t_flip

  task t_palm;
    wr(REG_CTRL, 16'h0001);
    snd(16'h0700, 16'h0480, 3'h1, 8'h20); `CHK(palm_flag, 1'b1)
    `CHK(abs_x, 16'h0000)
    snd(16'h0700, 16'h0480, 3'h1, 8'h01); `CHK(palm_flag, 1'b1)
    repeat (5) snd(16'h0000, 16'h0000, 3'h0, 8'h00);
    `CHK(palm_flag, 1'b0)
  endtask : t_palm

  // still finger: idle-touch after 400 ms, hold after 500 ms
  task t_hold;
    wr(REG_CTRL, 16'h0000); wr(REG_GEST_EN, 16'h0002);
    wr(REG_IDLE_MS, 16'h0190);
    repeat (6) snd(16'h0700, 16'h0480, 3'h1, 8'h01);
    `CHK(idle_touch, 1'b1)
    `CHK(hold_flag, 1'b0)
    snd(16'h0700, 16'h0480, 3'h1, 8'h01); `CHK(hold_flag, 1'b1)
    snd(16'h0800, 16'h0480, 3'h1, 8'h01); `CHK(rel_x, 16'h0036)
    `CHK(idle_touch, 1'b0)
    `CHK(hold_flag, 1'b1)
    snd(16'h0000, 16'h0000, 3'h0, 8'h00); `CHK(hold_flag, 1'b0)
  endtask : t_hold

  // averaged jump fires swipe x+, then static recursive filter
  task t_swipe;
    wr(REG_CTRL, 16'h0010); wr(REG_GEST_EN, 16'h0008);
    snd(16'h0700, 16'h0480, 3'h1, 8'h01);
    snd(16'h0e00, 16'h0480, 3'h1, 8'h01); `CHK(abs_x, 16'h0240)
    `CHK(swipe_flags, 4'h2)
    `CHK(rel_x, 16'h00c0)
    snd(16'h0e00, 16'h0480, 3'h1, 8'h01); `CHK(swipe_flags, 4'h0)
    snd(16'h0000, 16'h0000, 3'h0, 8'h00);
    wr(REG_CTRL, 16'h0060);
    snd(16'h0700, 16'h0480, 3'h1, 8'h01);
    snd(16'h0e00, 16'h0480, 3'h1, 8'h01); `CHK(abs_x, 16'h0240)
    snd(16'h0000, 16'h0000, 3'h0, 8'h00);
  endtask : t_swipe

  // hang guard, far above the roughly 130 cycles the tests need
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin fails++; results(); end
  end

  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    t_regs(); t_tap(); t_flip(); t_palm(); t_hold(); t_swipe();
    results();
  end
endmodule : testbench
